// ==== hdl/fsi_top.sv ====
// Purpose: Status, information and interrupt logic for four framers
// Assumes: Parallel port strobes are one-cycle and synchronous to CORE_CLK_I
// Notes: Read data appears one cycle after the read strobe, with a valid pulse
// Operation
// - Nine status-type registers per framer
// - Events latch bit at one until read
// - Read clears; alarms re-set while present
// - Mask one refreshes readable copy bit
// - Mask zero holds readable copy bit
// - Only status and link registers interrupt
// - Each interrupt source individually maskable
// - Alarm changes both ways raise interrupt
// - Alarm request released when bit read
// - Event raises interrupt when it occurs
// - Event request released when bit read
// - Some link controller bits stay live
// - Summary register shows requesting framer, type
// - Even summary bits show status requests
// - Odd summary bits show link requests
// - Summary answers any address A0 to FF
`timescale 1ns/1ps
`default_nettype none
module fsi_top (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire fsi_pkg::fsi_host_req_s HOST_REQ_I,
   input wire fsi_pkg::fsi_src_t STAT_SRC_I,
   output logic [7:0] RD_DATA_O,
   output logic RD_VALID_O,
   output logic INT_N_O
);
   import fsi_pkg::*;

   // Decode a status-type register offset: hit flag then index
   function automatic logic [4:0] stat_dec(input logic [7:0] addr);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 0; i < NUM_STAT; i++) begin
         if (addr == STAT_OFS[i]) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction

   // Decode a mask register offset: hit flag then index
   function automatic logic [2:0] mask_dec(input logic [7:0] addr);
      logic [2:0] res;
      res = 3'h0;
      for (int i = 0; i < NUM_MASK; i++) begin
         if (addr == MASK_OFS[i]) begin
            res = {1'b1, 2'(i)};
         end
      end
      return res;
   endfunction

   // Latched-bit mask per register index; the alarm mask is picked at the instance
   function automatic logic [7:0] latch_of(input int idx);
      logic [7:0] res;
      res = ALL_LATCHED;
      if (idx == IDX_HDLC_CONTROLLER_STATUS) begin
         res = HDLC_STAT_LATCH_MASK;
      end else if (idx == IDX_CODE_DETECT_STATUS) begin
         res = CODE_DET_LATCH_MASK;
      end else if (idx == IDX_LINK_FIFO_STATUS) begin
         res = FIFO_STAT_LATCH_MASK;
      end
      return res;
   endfunction

   fsi_top_state_s st_r;
   fsi_top_state_s st_nxt;
   logic [4:0] sdec;
   logic [2:0] mdec;
   logic sum_hit;
   logic [NUM_FRAMERS-1:0][NUM_STAT-1:0] stat_wr;
   logic [NUM_FRAMERS-1:0][NUM_STAT-1:0] stat_rd;
   logic [NUM_FRAMERS-1:0][NUM_STAT-1:0][7:0] stat_copy;
   logic [NUM_FRAMERS-1:0][NUM_STAT-1:0][7:0] stat_irq;

   // Address decode shared by strobes and the read mux
   assign sdec = stat_dec(HOST_REQ_I.addr);
   assign mdec = mask_dec(HOST_REQ_I.addr);
   assign sum_hit = HOST_REQ_I.addr >= FRAMER_INTERRUPT_SUMMARY_OFS;

   // Nine status-type registers for each framer
   for (genvar f = 0; f < NUM_FRAMERS; f++) begin : g_framer
      for (genvar r = 0; r < NUM_STAT; r++) begin : g_reg
         // Strobes reach only the addressed framer and register
         assign stat_wr[f][r] = HOST_REQ_I.wr && (HOST_REQ_I.framer == 2'(f))
            && sdec[4] && (sdec[3:0] == 4'(r));
         assign stat_rd[f][r] = HOST_REQ_I.rd && (HOST_REQ_I.framer == 2'(f))
            && sdec[4] && (sdec[3:0] == 4'(r));

         fsi_stat_reg #(
            .LATCH_MASK(latch_of(r)),
            .ALARM_MASK((r == IDX_ALARM_EVENT_STATUS_A) ? SR_A_ALARM_MASK
               : NO_ALARM_MASK)
         ) u_stat (
            .clk_i(CORE_CLK_I),
            .srst_i(SRST_I),
            .src_i(STAT_SRC_I[f][r]),
            .wr_i(stat_wr[f][r]),
            .rd_i(stat_rd[f][r]),
            .wdata_i(HOST_REQ_I.wdata),
            .copy_o(stat_copy[f][r]),
            .irq_src_o(stat_irq[f][r])
         );
      end
   end

   // Mask writes, summary, interrupt pin and read data
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;

      // Mask registers are plain read/write, per framer
      if (HOST_REQ_I.wr && !sum_hit && mdec[2]) begin
         st_nxt.mask[HOST_REQ_I.framer][mdec[1:0]] = HOST_REQ_I.wdata;
      end

      // Only the two status registers and the link registers feed requests;
      // the receive information registers never reach the pin
      for (int f = 0; f < NUM_FRAMERS; f++) begin
         st_nxt.summary[2*f] =
            (|(stat_irq[f][IDX_ALARM_EVENT_STATUS_A]
               & st_r.mask[f][IDX_IRQ_MASK_A]))
            | (|(stat_irq[f][IDX_ALARM_EVENT_STATUS_B]
               & st_r.mask[f][IDX_IRQ_MASK_B]));
         st_nxt.summary[2*f+1] =
            (|(stat_irq[f][IDX_HDLC_CONTROLLER_STATUS]
               & st_r.mask[f][IDX_HDLC_IRQ_MASK]))
            | (|(stat_irq[f][IDX_DATA_LINK_STATUS]
               & st_r.mask[f][IDX_DATA_LINK_IRQ_MASK]));
      end

      // Pin stays low while any framer has a request
      st_nxt.int_n = ~(|st_nxt.summary);

      // Read mux; the summary wins over per-framer offsets in its range
      if (HOST_REQ_I.rd) begin
         st_nxt.rvalid = 1'b1;
         if (sum_hit) begin
            st_nxt.rdata = st_r.summary;
         end else if (mdec[2]) begin
            st_nxt.rdata = st_r.mask[HOST_REQ_I.framer][mdec[1:0]];
         end else if (sdec[4]) begin
            // Copy as it stands now; the same edge clears the reported bits
            st_nxt.rdata = stat_copy[HOST_REQ_I.framer][sdec[3:0]];
         end else begin
            st_nxt.rdata = UNMAPPED_READ;
         end
      end
   end

   // Registered state; writes into the summary range simply fall through
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         st_r.mask <= {(NUM_FRAMERS * NUM_MASK){MASK_RST}};
         st_r.summary <= SUMMARY_RST;
         st_r.rdata <= 8'h00;
         st_r.rvalid <= 1'b0;
         st_r.int_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // All outputs come straight from flip-flops
   assign RD_DATA_O = st_r.rdata;
   assign RD_VALID_O = st_r.rvalid;
   assign INT_N_O = st_r.int_n;

endmodule
`default_nettype wire

// ==== hdl/fsi_pkg.sv ====
// Purpose: Shared constants and types for the framer status and interrupt logic
// Assumes: Four framers, nine status-type registers and four mask registers each
// Notes: Offsets are port addresses within one framer's register space
package fsi_pkg;

   localparam int NUM_FRAMERS = 4;
   localparam int NUM_STAT = 9;
   localparam int NUM_MASK = 4;

   // Status-type register indices
   localparam int IDX_ALARM_EVENT_STATUS_A = 0;
   localparam int IDX_ALARM_EVENT_STATUS_B = 1;
   localparam int IDX_RECEIVE_INFO_A = 2;
   localparam int IDX_RECEIVE_INFO_B = 3;
   localparam int IDX_RECEIVE_INFO_C = 4;
   localparam int IDX_DATA_LINK_STATUS = 5;
   localparam int IDX_HDLC_CONTROLLER_STATUS = 6;
   localparam int IDX_CODE_DETECT_STATUS = 7;
   localparam int IDX_LINK_FIFO_STATUS = 8;

   // Status-type register offsets, in index order (index 0 in the low byte)
   localparam logic [NUM_STAT-1:0][7:0] STAT_OFS = {
      8'h93, 8'h92, 8'h91, 8'h90, 8'h10, 8'h31, 8'h22, 8'h21, 8'h20};

   // Mask register indices and offsets
   localparam int IDX_IRQ_MASK_A = 0;
   localparam int IDX_IRQ_MASK_B = 1;
   localparam int IDX_HDLC_IRQ_MASK = 2;
   localparam int IDX_DATA_LINK_IRQ_MASK = 3;
   localparam logic [NUM_MASK-1:0][7:0] MASK_OFS = {8'h95, 8'h94, 8'h17, 8'h16};
   localparam logic [7:0] MASK_RST = 8'h00;

   // Summary register: any address from its base up to the top of the map
   localparam logic [7:0] FRAMER_INTERRUPT_SUMMARY_OFS = 8'hA0;
   localparam logic [7:0] SUMMARY_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Alarm-type bits of alarm_event_status_a: yellow, carrier loss, blue,
   // sync loss, transmit clock loss on bits 0 to 4
   localparam logic [7:0] SR_A_ALARM_MASK = 8'h1F;
   localparam logic [7:0] NO_ALARM_MASK = 8'h00;
   // Latched bit masks; a zero marks a live, non-latched bit
   localparam logic [7:0] ALL_LATCHED = 8'hFF;
   localparam logic [7:0] HDLC_STAT_LATCH_MASK = 8'h3F;
   localparam logic [7:0] CODE_DET_LATCH_MASK = 8'hFE;
   localparam logic [7:0] FIFO_STAT_LATCH_MASK = 8'h00;

   // Parallel port request, one cycle per access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [1:0] framer;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fsi_host_req_s;

   // Raw sources: event pulses or alarm levels per framer and register
   typedef logic [NUM_FRAMERS-1:0][NUM_STAT-1:0][7:0] fsi_src_t;

   // State of one status-type register
   typedef struct packed {
      logic [7:0] lat;
      logic [7:0] copy;
      logic [7:0] sel;
      logic [7:0] alm_prev;
      logic [7:0] alm_pend;
   } fsi_stat_state_s;

   // State of the top block
   typedef struct packed {
      logic [NUM_FRAMERS-1:0][NUM_MASK-1:0][7:0] mask;
      logic [7:0] summary;
      logic [7:0] rdata;
      logic rvalid;
      logic int_n;
   } fsi_top_state_s;

endpackage

// ==== hdl/fsi_stat_reg.sv ====
// Purpose: One status-type register with latch, readable copy and irq sources
// Assumes: Sources sampled on the core clock; read and write strobes one cycle
// Notes: Live bits follow their source; alarm bits raise a request on each change
`timescale 1ns/1ps
`default_nettype none
module fsi_stat_reg #(
   parameter logic [7:0] LATCH_MASK = 8'hFF,
   parameter logic [7:0] ALARM_MASK = 8'h00
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] src_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] copy_o,
   output logic [7:0] irq_src_o
);
   import fsi_pkg::*;

   fsi_stat_state_s st_r;
   fsi_stat_state_s st_nxt;
   logic [7:0] rd_clr;
   logic [7:0] alm_chg;

   // Next state; every set term is ORed last so a new event beats a clear
   always_comb begin
      st_nxt = st_r;
      rd_clr = rd_i ? (st_r.sel & st_r.copy) : 8'h00;
      alm_chg = (src_i ^ st_r.alm_prev) & ALARM_MASK;
      // Latched bits hold until reported by a read; alarms re-set while present
      st_nxt.lat = (((st_r.lat & ~rd_clr) | src_i) & LATCH_MASK)
         | (src_i & ~LATCH_MASK);
      st_nxt.alm_prev = src_i & ALARM_MASK;
      // A read of the selected bits releases their alarm requests
      st_nxt.alm_pend = ((st_r.alm_pend & ~(rd_i ? st_r.sel : 8'h00)) | alm_chg)
         & ALARM_MASK;
      if (wr_i) begin
         st_nxt.copy = (wdata_i & st_r.lat) | (~wdata_i & st_r.copy);
         st_nxt.sel = wdata_i;
      end
   end

   // Registered state
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign copy_o = st_r.copy;
   // Events request until read; alarms only through their change flags
   assign irq_src_o = (st_r.lat & ~ALARM_MASK & LATCH_MASK) | st_r.alm_pend;

endmodule
`default_nettype wire

// ==== testbench/fsi_sva.sv ====
// Purpose: Port checks for the framer status and interrupt block
// Assumes: One clock, synchronous active-high reset
// Notes: Age counters bound how long a cause may precede its effect
`timescale 1ns/1ps
`default_nettype none
module fsi_sva (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire fsi_pkg::fsi_host_req_s HOST_REQ_I,
   input wire fsi_pkg::fsi_src_t STAT_SRC_I,
   input wire logic [7:0] RD_DATA_O,
   input wire logic RD_VALID_O,
   input wire logic INT_N_O
);
   import fsi_pkg::*;
   logic [3:0] acc_age_r;
   logic [3:0] cause_age_r;
   logic mask_on_r;
   fsi_src_t src_prev_r;
   // Ages saturate so an old cause never wraps back into range
   always_ff @(posedge CORE_CLK_I) begin
      src_prev_r <= STAT_SRC_I;
      if (SRST_I) begin
         acc_age_r <= 4'hF;
         cause_age_r <= 4'hF;
         mask_on_r <= 1'b0;
      end else begin
         acc_age_r <= (HOST_REQ_I.rd || HOST_REQ_I.wr) ? 4'h0 : acc_age_r + 4'(acc_age_r != 4'hF);
         cause_age_r <= (HOST_REQ_I.wr || STAT_SRC_I != src_prev_r) ? 4'h0 :
            cause_age_r + 4'(cause_age_r != 4'hF);
         mask_on_r <= mask_on_r | (HOST_REQ_I.wr && HOST_REQ_I.wdata != 8'h00 &&
            HOST_REQ_I.addr inside {MASK_OFS[0], MASK_OFS[1], MASK_OFS[2], MASK_OFS[3]});
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);
   a_summary_answer: assert property (HOST_REQ_I.rd && HOST_REQ_I.addr >= 8'hA0
      |=> RD_VALID_O) else $error("summary read not answered");
   a_valid_cause: assert property (RD_VALID_O |-> $past(HOST_REQ_I.rd))
      else $error("read valid without read");
   a_rdata_hold: assert property (!$past(SRST_I) && !$past(HOST_REQ_I.rd) |-> $stable(RD_DATA_O))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (HOST_REQ_I.rd && HOST_REQ_I.addr == 8'h00 |=>
      RD_DATA_O == UNMAPPED_READ) else $error("unmapped read not zero");
   a_int_reset: assert property ($fell(SRST_I) |-> INT_N_O)
      else $error("interrupt low after reset");
   a_int_masked: assert property (!mask_on_r |-> INT_N_O)
      else $error("interrupt with all masks off");
   a_int_release: assert property (!$past(SRST_I) && $rose(INT_N_O)
      |-> acc_age_r <= 4'h5) else $error("interrupt released without host access");
   a_int_raise: assert property ($fell(INT_N_O) |-> cause_age_r <= 4'h4)
      else $error("interrupt raised without a cause");
   c_int_fall: cover property ($fell(INT_N_O));
   c_int_rise: cover property ($rose(INT_N_O));
   c_rd_nonzero: cover property (RD_VALID_O && RD_DATA_O != 8'h00);
endmodule
`default_nettype wire

// ==== testbench/fsi_src_model.sv ====
// Purpose: Far-side model driving the framer status sources
// Assumes: Sources change just after the rising clock edge
// Notes: Events are one-cycle pulses, alarms are held levels
`timescale 1ns/1ps
`default_nettype none
module fsi_src_model (
   input wire logic clk_i,
   output wire fsi_pkg::fsi_src_t src_o
);
   import fsi_pkg::*;
   fsi_src_t lvl = '0;
   fsi_src_t pls = '0;
   // Kept apart so a pulse never disturbs a held alarm
   assign src_o = lvl | pls;
   // One-cycle event pulse
   task automatic pulse(input int f, input int idx, input logic [7:0] b);
      @(posedge clk_i);
      #2;
      pls[f][idx] = b;
      @(posedge clk_i);
      #2;
      pls[f][idx] = 8'h00;
   endtask
   // Alarm level, held until changed
   task automatic level(input int f, input int idx, input logic [7:0] b);
      @(posedge clk_i);
      #2;
      lvl[f][idx] = b;
   endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the framer status and interrupt block
// Assumes: One-cycle host strobes with an idle cycle between them
// Notes: Reads queue their expected byte; a monitor compares on read valid
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module testbench;
   import fsi_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   fsi_host_req_s req = '0;
   fsi_src_t src;
   logic [7:0] rd_data;
   logic rd_valid;
   logic int_n;
   logic [7:0] exp_q[$];
   logic [7:0] mon_e;
   logic [7:0] b;
   logic [31:0] lfsr = 32'h292F;
   int i;
   int mi;
   int fail_count = 0;
   int n_compared = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   fsi_src_model u_src (.clk_i(clk), .src_o(src));
   fsi_top u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .HOST_REQ_I(req), .STAT_SRC_I(src),
      .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .INT_N_O(int_n));
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // One access, then an idle cycle so no strobe is assigned twice at once
   task automatic acc(input logic w, input logic [1:0] f, input logic [7:0] a,
         input logic [7:0] d);
      @(posedge clk);
      #2;
      req = '{wr: w, rd: ~w, framer: f, addr: a, wdata: d};
      @(posedge clk);
      #2;
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask
   task automatic rd(input logic [1:0] f, input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, f, a, 8'h00);
   endtask
   task automatic poll(input logic [1:0] f, input int x, input logic [7:0] m,
         input logic [7:0] e);
      acc(1'b1, f, STAT_OFS[x], m);
      rd(f, STAT_OFS[x], e);
      acc(1'b1, f, STAT_OFS[x], e & m);
   endtask
   task automatic chk_int(input logic e);
      repeat (4) @(posedge clk);
      #2;
      `CHK("int_n", e, int_n)
   endtask
   task automatic report_and_stop();
      // A read that was never answered still owes its comparison
      if (exp_q.size() != 0) begin
         fail_count++;
         $display("unexpected pending_reads exp=0 got=%0d", exp_q.size());
      end
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Each read answer retires the oldest expectation
   always @(negedge clk) begin
      if (rd_valid === 1'b1 && exp_q.size() == 0) begin
         fail_count++;
         $display("unexpected rd_valid exp=0 got=1");
      end else if (rd_valid === 1'b1) begin
         mon_e = exp_q.pop_front();
         `CHK("rd_data", mon_e, rd_data)
      end
   end
   // The sequence needs well under a thousand cycles
   initial begin
      #(50 * 20000);
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge clk);
      #2;
      srst = 1'b0;
      rd(2'd0, FRAMER_INTERRUPT_SUMMARY_OFS, SUMMARY_RST);
      acc(1'b1, 2'd0, 8'hC3, 8'hFF);
      rd(2'd3, 8'hFF, 8'h00);
      rd(2'd0, 8'h00, UNMAPPED_READ);
      chk_int(1'b1);
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         lfsr = step(lfsr);
         i = IDX_RECEIVE_INFO_A + int'(lfsr[11:10]) % 3;
         u_src.pulse(lfsr[9:8], i, lfsr[7:0]);
         poll(lfsr[9:8], i, 8'hFF, lfsr[7:0]);
         poll(lfsr[9:8], i, 8'hFF, 8'h00);
      end
      u_src.pulse(0, IDX_ALARM_EVENT_STATUS_B, 8'h40);
      acc(1'b1, 2'd0, STAT_OFS[IDX_ALARM_EVENT_STATUS_B], 8'h40);
      rd(2'd0, STAT_OFS[IDX_ALARM_EVENT_STATUS_B], 8'h40);
      acc(1'b1, 2'd0, STAT_OFS[IDX_ALARM_EVENT_STATUS_B], 8'h00);
      rd(2'd0, STAT_OFS[IDX_ALARM_EVENT_STATUS_B], 8'h40);
      poll(2'd0, IDX_ALARM_EVENT_STATUS_B, 8'h40, 8'h00);
      $display("test latch done");
      // Status, link controller and data link sources of every framer in turn
      for (int fr = 0; fr < 4; fr++) begin
         for (int h = 0; h < 3; h++) begin
            i = (h == 2) ? IDX_DATA_LINK_STATUS : h ? IDX_HDLC_CONTROLLER_STATUS
               : IDX_ALARM_EVENT_STATUS_B;
            mi = (h == 2) ? IDX_DATA_LINK_IRQ_MASK : h ? IDX_HDLC_IRQ_MASK : IDX_IRQ_MASK_B;
            b = (h == 2) ? 8'h02 : h ? 8'h01 : 8'h08;
            lfsr = step(lfsr);
            u_src.pulse(fr, i, b);
            chk_int(1'b1);
            acc(1'b1, 2'(fr), MASK_OFS[mi], b);
            chk_int(1'b0);
            rd(lfsr[13:12], 8'hA0 + {3'h0, lfsr[4:0]},
               8'(1 << (2 * fr + (h != 0))));
            poll(2'(fr), i, b, b);
            chk_int(1'b1);
            rd(lfsr[15:14], FRAMER_INTERRUPT_SUMMARY_OFS, 8'h00);
            acc(1'b1, 2'(fr), MASK_OFS[mi], 8'h00);
         end
      end
      $display("test event interrupt done");
      acc(1'b1, 2'd2, MASK_OFS[IDX_IRQ_MASK_A], 8'h01);
      u_src.level(2, IDX_ALARM_EVENT_STATUS_A, 8'h01);
      chk_int(1'b0);
      poll(2'd2, IDX_ALARM_EVENT_STATUS_A, 8'h01, 8'h01);
      chk_int(1'b1);
      poll(2'd2, IDX_ALARM_EVENT_STATUS_A, 8'h01, 8'h01);
      chk_int(1'b1);
      u_src.level(2, IDX_ALARM_EVENT_STATUS_A, 8'h00);
      chk_int(1'b0);
      poll(2'd2, IDX_ALARM_EVENT_STATUS_A, 8'h01, 8'h01);
      chk_int(1'b1);
      poll(2'd2, IDX_ALARM_EVENT_STATUS_A, 8'h01, 8'h00);
      $display("test alarm done");
      u_src.pulse(3, IDX_HDLC_CONTROLLER_STATUS, 8'hE0);
      poll(2'd3, IDX_HDLC_CONTROLLER_STATUS, 8'hE0, 8'h20);
      $display("test live bits done");
      // Mid-run reset must drop masks and latched bits alike
      rd(2'd2, MASK_OFS[IDX_IRQ_MASK_A], 8'h01);
      u_src.pulse(1, IDX_ALARM_EVENT_STATUS_B, 8'h10);
      @(posedge clk);
      #2;
      srst = 1'b1;
      repeat (2) @(posedge clk);
      #2;
      srst = 1'b0;
      rd(2'd2, MASK_OFS[IDX_IRQ_MASK_A], MASK_RST);
      poll(2'd1, IDX_ALARM_EVENT_STATUS_B, 8'hFF, 8'h00);
      chk_int(1'b1);
      $display("test mid reset done");
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule
bind fsi_top fsi_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I),
   .HOST_REQ_I(HOST_REQ_I), .STAT_SRC_I(STAT_SRC_I), .RD_DATA_O(RD_DATA_O),
   .RD_VALID_O(RD_VALID_O), .INT_N_O(INT_N_O));
`default_nettype wire
